// ==== slcd_ctrl.sv ====
/*
 * Segment LCD controller: control registers, display memory, clock
 * dividers and common/segment waveform sequencing behind AXI4-Lite.
 * Assumes sub_clk_tick and osc_tick are one-cycle enables synchronous to
 * clk, and an external analog stage turns level codes into voltages.
 */
// Functional notes
// - Drive-voltage register resets to zero, resistors disconnected.
// - Voltage field: 00 power save, 01 divide, 11 divide with step-down.
// - Display mode register resets to zero: off, ground, four slices.
// - With pin control high, display enable low forces all segments to deselect level.
// - Pin control low grounds all pins; high drives deselect and commons.
// - Mode 00 four slices, 01 three slices, 10 static, 1/3 bias.
// - Clock register resets to zero: subsystem clock, divide by 16.
// - Source: subsystem, peripheral /128 /256 /512, or oscillator /8.
// - Display clock divides source by 2^4 to 2^9 for codes 0-5.
// - Frame rate follows display clock and number of slices.
// - Port0 select bit n hands pin P0n to segment use.
// - Port3 select bit n hands pin P3n to segment use.
// - Grouped register hands P7 upper nibble, P13-P16, port 8, port 9.
// - Byte and single-bit writes leave other bits undisturbed.
// - Forty segment outputs and four common outputs.
// - Memory bits 0-3 drive segments while commons 0-3 are selected.
// - Static drives all commons alike; three-slice leaves fourth unused.
`timescale 1ns/10ps
module slcd_ctrl
    import slcd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Clock sources, one-cycle enables
    input wire logic sub_clk_tick,
    input wire logic osc_tick,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Panel drive
    output slcd_level_t [SEG_COUNT-1:0] seg_level,
    output slcd_level_t [COM_COUNT-1:0] com_level,
    // Analog and pin-mux control
    output slcd_drive_t drive_cfg,
    output slcd_pinsel_t pin_sel
);

    logic [7:0] drive_voltage_config_q;
    logic [7:0] display_mode_control_q;
    logic [7:0] display_clock_control_q;
    logic [7:0] segment_pin_select_port0_q;
    logic [7:0] segment_pin_select_port3_q;
    logic [7:0] segment_pin_select_grouped_q;
    logic [3:0] disp_mem_q [SEG_COUNT];

    logic aw_hold_q;
    logic w_hold_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic do_write;

    logic [8:0] prs_cnt_q;
    logic [2:0] osc_cnt_q;
    logic [8:0] disp_cnt_q;
    logic src_tick;
    logic disp_tick;
    logic [1:0] com_idx_q;
    logic polarity_q;

    logic display_enable;
    logic pin_output_control;
    logic [1:0] slice_mode;
    logic [2:0] src_sel;
    logic [2:0] frame_div;

    // True when addr hits the word of the given register index
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
        addr_hit = (addr == {idx, 2'b00});
    endfunction : addr_hit

    // Display memory slot for addr, or SEG_COUNT when outside memory
    function automatic logic [5:0] mem_slot(input logic [ADDR_W-1:0] addr);
        logic [15:0] idx;
        logic [15:0] off;
        idx = addr[ADDR_W-1:2];
        off = idx - IDX_DISP_MEM_BASE;
        if (addr[1:0] == 2'b00 && idx >= IDX_DISP_MEM_BASE && off < 16'(SEG_COUNT)) begin
            mem_slot = off[5:0];
        end else begin
            mem_slot = 6'(SEG_COUNT);
        end
    endfunction : mem_slot

    // Low-bit mask for a divide by 2^(4+code)
    function automatic logic [8:0] div_mask(input logic [2:0] code);
        logic [9:0] one_hot;
        one_hot = 10'h001 << (FRAME_DIV_BASE_LOG2 + int'(code));
        div_mask = 9'(one_hot - 10'h001);
    endfunction : div_mask

    // Level of a common pin: selected or not, in the current frame half
    function automatic slcd_level_t com_drive(input logic sel, input logic pol,
                                              input logic is_static);
        if (is_static || sel) begin
            com_drive = pol ? LV_GND : LV_VLC0;
        end else begin
            com_drive = pol ? LV_VLC1 : LV_VLC2;
        end
    endfunction : com_drive

    // Level of a segment pin; static deselect equals the common level
    function automatic slcd_level_t seg_drive(input logic sel, input logic pol,
                                              input logic is_static);
        if (sel) begin
            seg_drive = pol ? LV_VLC0 : LV_GND;
        end else if (is_static) begin
            seg_drive = pol ? LV_GND : LV_VLC0;
        end else begin
            seg_drive = pol ? LV_VLC2 : LV_VLC1;
        end
    endfunction : seg_drive

    // Field views of the control registers
    assign display_enable = display_mode_control_q[DISPLAY_ENABLE_BIT];
    assign pin_output_control = display_mode_control_q[PIN_OUTPUT_CONTROL_BIT];
    assign slice_mode = {display_mode_control_q[SLICE_MODE_SEL_HI_BIT],
                         display_mode_control_q[SLICE_MODE_SEL_LO_BIT]};
    assign src_sel = display_clock_control_q[SRC_CLK_LSB +: 3];
    assign frame_div = display_clock_control_q[FRAME_DIV_LSB +: 3];

    // AXI write channel: address and data taken independently
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_hold_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
        end
    end

    // Only byte lane 0 carries register data; wider lanes are ignored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            w_hold_q <= 1'b0;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata[7:0];
            wstrb_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            if (addr_hit(awaddr_q, IDX_DRIVE_VOLTAGE) || addr_hit(awaddr_q, IDX_DISPLAY_MODE)
                || addr_hit(awaddr_q, IDX_DISPLAY_CLOCK)
                || addr_hit(awaddr_q, IDX_PIN_SEL_PORT0)
                || addr_hit(awaddr_q, IDX_PIN_SEL_PORT3)
                || addr_hit(awaddr_q, IDX_PIN_SEL_GROUPED)
                || addr_hit(awaddr_q, IDX_DISPLAY_STATUS)
                || mem_slot(awaddr_q) != 6'(SEG_COUNT)) begin
                bresp_q <= RESP_OKAY;
            end else begin
                bresp_q <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Control registers; a whole-byte write replaces only writable bits,
    // so a read-modify-write of one bit leaves its neighbours intact
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drive_voltage_config_q <= RST_DRIVE_VOLTAGE;
            display_mode_control_q <= RST_DISPLAY_MODE;
            display_clock_control_q <= RST_DISPLAY_CLOCK;
            segment_pin_select_port0_q <= RST_PIN_SEL;
            segment_pin_select_port3_q <= RST_PIN_SEL;
            segment_pin_select_grouped_q <= RST_PIN_SEL;
        end else if (do_write && wstrb_q) begin
            if (addr_hit(awaddr_q, IDX_DRIVE_VOLTAGE)) begin
                drive_voltage_config_q <= wdata_q & MASK_DRIVE_VOLTAGE;
            end
            if (addr_hit(awaddr_q, IDX_DISPLAY_MODE)) begin
                display_mode_control_q <= wdata_q & MASK_DISPLAY_MODE;
            end
            if (addr_hit(awaddr_q, IDX_DISPLAY_CLOCK)) begin
                display_clock_control_q <= wdata_q & MASK_DISPLAY_CLOCK;
            end
            if (addr_hit(awaddr_q, IDX_PIN_SEL_PORT0)) begin
                segment_pin_select_port0_q <= wdata_q;
            end
            if (addr_hit(awaddr_q, IDX_PIN_SEL_PORT3)) begin
                segment_pin_select_port3_q <= wdata_q;
            end
            if (addr_hit(awaddr_q, IDX_PIN_SEL_GROUPED)) begin
                segment_pin_select_grouped_q <= wdata_q & MASK_PIN_SEL_GROUPED;
            end
        end
    end

    // Display memory holds no reset: contents are software's job
    always_ff @(posedge clk) begin
        if (do_write && wstrb_q && mem_slot(awaddr_q) != 6'(SEG_COUNT)) begin
            disp_mem_q[mem_slot(awaddr_q)] <= wdata_q[3:0];
        end
    end

    // AXI read channel: one-cycle answer from a registered mux
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            if (addr_hit(s_axi_araddr, IDX_DRIVE_VOLTAGE)) begin
                rdata_q[7:0] <= drive_voltage_config_q;
            end else if (addr_hit(s_axi_araddr, IDX_DISPLAY_MODE)) begin
                rdata_q[7:0] <= display_mode_control_q;
            end else if (addr_hit(s_axi_araddr, IDX_DISPLAY_CLOCK)) begin
                rdata_q[7:0] <= display_clock_control_q;
            end else if (addr_hit(s_axi_araddr, IDX_PIN_SEL_PORT0)) begin
                rdata_q[7:0] <= segment_pin_select_port0_q;
            end else if (addr_hit(s_axi_araddr, IDX_PIN_SEL_PORT3)) begin
                rdata_q[7:0] <= segment_pin_select_port3_q;
            end else if (addr_hit(s_axi_araddr, IDX_PIN_SEL_GROUPED)) begin
                rdata_q[7:0] <= segment_pin_select_grouped_q;
            end else if (addr_hit(s_axi_araddr, IDX_DISPLAY_STATUS)) begin
                rdata_q[2:0] <= {polarity_q, com_idx_q};
            end else if (mem_slot(s_axi_araddr) != 6'(SEG_COUNT)) begin
                rdata_q[3:0] <= disp_mem_q[mem_slot(s_axi_araddr)];
            end else begin
                rresp_q <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Peripheral prescaler runs from clk itself
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prs_cnt_q <= 9'h000;
        end else begin
            prs_cnt_q <= prs_cnt_q + 9'h001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_cnt_q <= 3'h0;
        end else if (osc_tick) begin
            osc_cnt_q <= osc_cnt_q + 3'h1;
        end
    end

    // Source clock select; prohibited codes stop the display clock
    always_comb begin
        case (src_sel)
            SRC_SUBSYSTEM: src_tick = sub_clk_tick;
            SRC_PRS_DIV128: src_tick = (prs_cnt_q[6:0] == PRS_DIV128_LAST[6:0]);
            SRC_PRS_DIV256: src_tick = (prs_cnt_q[7:0] == PRS_DIV256_LAST[7:0]);
            SRC_PRS_DIV512: src_tick = (prs_cnt_q == PRS_DIV512_LAST);
            SRC_OSC_DIV8: src_tick = osc_tick && (osc_cnt_q == OSC_DIV8_LAST);
            default: src_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            disp_cnt_q <= 9'h000;
        end else if (src_tick) begin
            disp_cnt_q <= disp_cnt_q + 9'h001;
        end
    end

    // Display clock: source divided by 2^(4+code)
    assign disp_tick = src_tick && frame_div <= FRAME_DIV_MAX
        && (disp_cnt_q & div_mask(frame_div)) == div_mask(frame_div);

    // Common sequencer; frame length is slice count display clocks
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            com_idx_q <= 2'h0;
            polarity_q <= 1'b0;
        end else if (!pin_output_control) begin
            com_idx_q <= 2'h0;
            polarity_q <= 1'b0;
        end else if (disp_tick) begin
            case (slice_mode)
                MODE_FOUR_SLICE: begin
                    com_idx_q <= com_idx_q + 2'h1;
                    if (com_idx_q == 2'h3) begin
                        polarity_q <= !polarity_q;
                    end
                end
                MODE_THREE_SLICE: begin
                    if (com_idx_q >= 2'h2) begin
                        com_idx_q <= 2'h0;
                        polarity_q <= !polarity_q;
                    end else begin
                        com_idx_q <= com_idx_q + 2'h1;
                    end
                end
                default: begin
                    com_idx_q <= 2'h0;
                    polarity_q <= !polarity_q;
                end
            endcase
        end
    end

    // Pin levels, registered so the panel sees clean edges
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            com_level <= '{default: LV_GND};
            seg_level <= '{default: LV_GND};
        end else begin
            for (int c = 0; c < COM_COUNT; c++) begin
                if (!pin_output_control) begin
                    com_level[c] <= LV_GND;
                end else if (slice_mode == MODE_THREE_SLICE && c == COM_COUNT - 1) begin
                    // Unused common: held at ground, the panel leaves it open
                    com_level[c] <= LV_GND;
                end else begin
                    com_level[c] <= com_drive(com_idx_q == 2'(c), polarity_q,
                                              slice_mode[1]);
                end
            end
            for (int s = 0; s < SEG_COUNT; s++) begin
                if (!pin_output_control) begin
                    seg_level[s] <= LV_GND;
                end else if (!display_enable) begin
                    seg_level[s] <= seg_drive(1'b0, polarity_q, slice_mode[1]);
                end else begin
                    seg_level[s] <= seg_drive(disp_mem_q[s][com_idx_q], polarity_q,
                                              slice_mode[1]);
                end
            end
        end
    end

    // Voltage generator decode; prohibited codes leave resistors off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drive_cfg <= '0;
        end else begin
            case (drive_voltage_config_q[VGEN_LSB +: 2])
                VGEN_DIVIDE: drive_cfg <= '{resistor_on: 1'b1, step_down: 1'b0};
                VGEN_DIVIDE_STEP_DOWN: drive_cfg <= '{resistor_on: 1'b1, step_down: 1'b1};
                default: drive_cfg <= '{resistor_on: 1'b0, step_down: 1'b0};
            endcase
        end
    end

    // Pin function routing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_sel <= '0;
        end else begin
            pin_sel.port0 <= segment_pin_select_port0_q;
            pin_sel.port3 <= segment_pin_select_port3_q;
            pin_sel.port7_upper_nibble <= segment_pin_select_grouped_q[7];
            pin_sel.port1_single <= segment_pin_select_grouped_q[6:3];
            pin_sel.port9_whole <= segment_pin_select_grouped_q[2];
            pin_sel.port8_whole <= segment_pin_select_grouped_q[1];
        end
    end

endmodule : slcd_ctrl

// ==== slcd_pkg.sv ====
/*
 * Shared constants and types for the segment LCD control block:
 * register indices, field positions, reset values, level codes, carriers.
 * Assumes a 32-bit AXI4-Lite register port where each register index
 * maps to the byte address index*4.
 */
package slcd_pkg;

    // Register indices (byte address is index * 4)
    localparam logic [15:0] IDX_PIN_SEL_PORT3 = 16'hff0d;
    localparam logic [15:0] IDX_PIN_SEL_GROUPED = 16'hff1a;
    localparam logic [15:0] IDX_PIN_SEL_PORT0 = 16'hff1b;
    localparam logic [15:0] IDX_DRIVE_VOLTAGE = 16'hff5a;
    localparam logic [15:0] IDX_DISPLAY_MODE = 16'hff5b;
    localparam logic [15:0] IDX_DISPLAY_CLOCK = 16'hff5c;
    localparam logic [15:0] IDX_DISPLAY_STATUS = 16'hff5d;
    localparam logic [15:0] IDX_DISP_MEM_BASE = 16'hf9d0;

    localparam int SEG_COUNT = 40;
    localparam int COM_COUNT = 4;
    localparam int ADDR_W = 18;

    // Reset values
    localparam logic [7:0] RST_DRIVE_VOLTAGE = 8'h00;
    localparam logic [7:0] RST_DISPLAY_MODE = 8'h00;
    localparam logic [7:0] RST_DISPLAY_CLOCK = 8'h00;
    localparam logic [7:0] RST_PIN_SEL = 8'h00;

    // Writable bit masks; reserved bits read as zero
    localparam logic [7:0] MASK_DRIVE_VOLTAGE = 8'h30;
    localparam logic [7:0] MASK_DISPLAY_MODE = 8'hc5;
    localparam logic [7:0] MASK_DISPLAY_CLOCK = 8'h77;
    localparam logic [7:0] MASK_PIN_SEL_GROUPED = 8'hfe;

    // Field positions
    localparam int VGEN_LSB = 4;
    localparam int DISPLAY_ENABLE_BIT = 7;
    localparam int PIN_OUTPUT_CONTROL_BIT = 6;
    localparam int SLICE_MODE_SEL_HI_BIT = 2;
    localparam int SLICE_MODE_SEL_LO_BIT = 0;
    localparam int SRC_CLK_LSB = 4;
    localparam int FRAME_DIV_LSB = 0;

    // Field codes
    localparam logic [1:0] VGEN_POWER_SAVE = 2'h0;
    localparam logic [1:0] VGEN_DIVIDE = 2'h1;
    localparam logic [1:0] VGEN_DIVIDE_STEP_DOWN = 2'h3;
    localparam logic [1:0] MODE_FOUR_SLICE = 2'h0;
    localparam logic [1:0] MODE_THREE_SLICE = 2'h1;
    localparam logic [1:0] MODE_STATIC = 2'h2;
    localparam logic [2:0] SRC_SUBSYSTEM = 3'h0;
    localparam logic [2:0] SRC_PRS_DIV128 = 3'h1;
    localparam logic [2:0] SRC_PRS_DIV256 = 3'h2;
    localparam logic [2:0] SRC_PRS_DIV512 = 3'h3;
    localparam logic [2:0] SRC_OSC_DIV8 = 3'h4;
    localparam logic [2:0] FRAME_DIV_MAX = 3'h5;
    localparam int FRAME_DIV_BASE_LOG2 = 4;

    // Divider terminal counts (cycles minus one)
    localparam logic [8:0] PRS_DIV128_LAST = 9'h07f;
    localparam logic [8:0] PRS_DIV256_LAST = 9'h0ff;
    localparam logic [8:0] PRS_DIV512_LAST = 9'h1ff;
    localparam logic [2:0] OSC_DIV8_LAST = 3'h7;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin drive levels; VLC0 is the full panel drive voltage
    typedef enum logic [1:0] {
        LV_GND = 2'h0,
        LV_VLC2 = 2'h1,
        LV_VLC1 = 2'h2,
        LV_VLC0 = 2'h3
    } slcd_level_t;

    typedef struct packed {
        logic resistor_on;
        logic step_down;
    } slcd_drive_t;

    typedef struct packed {
        logic [7:0] port0;
        logic [7:0] port3;
        logic port7_upper_nibble;
        logic [3:0] port1_single;
        logic port9_whole;
        logic port8_whole;
    } slcd_pinsel_t;

endpackage : slcd_pkg

// ==== slcd_ctrl_assertions.sv ====
/* Port checks for the segment LCD control block: bus handshakes and drive codes.
   Assumes binding to slcd_ctrl, one clock, asynchronous active-low reset. */
`timescale 1ns/10ps
module slcd_ctrl_assertions
    import slcd_pkg::*;
(
    // Watched ports of slcd_ctrl
    input wire logic clk,
    input wire logic nrst,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire slcd_drive_t drive_cfg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address ready while response pending");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while data pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_bresp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returns data");
    a_vgen_code: assert property (drive_cfg.step_down |-> drive_cfg.resistor_on)
        else $error("step-down without divider");
endmodule : slcd_ctrl_assertions

bind slcd_ctrl slcd_ctrl_assertions chk_i (.clk, .nrst, .s_axi_awready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rdata, .s_axi_rresp, .drive_cfg);

// ==== slcd_panel.sv ====
/* Passive glass model: a first-row pixel lights at full common/segment swing.
   Assumes level codes from slcd_pkg. */
`timescale 1ns/10ps
module slcd_panel
    import slcd_pkg::*;
(
    // Electrodes and first-row pixels
    input wire slcd_level_t [SEG_COUNT-1:0] seg_level,
    input wire slcd_level_t [COM_COUNT-1:0] com_level,
    output logic [SEG_COUNT-1:0] pix_on
);
    // Only VLC0 against GND lights; the 1/3 swings stay dark
    always_comb begin
        for (int i = 0; i < SEG_COUNT; i++) begin
            pix_on[i] = {com_level[0], seg_level[i]} inside {4'hc, 4'h3};
        end
    end
endmodule : slcd_panel

// ==== tb_segment_lcd_control_regs.sv ====
/* Self-checking bench for slcd_ctrl over AXI4-Lite with a passive panel.
   Assumes slcd_pkg, slcd_ctrl, its checker and slcd_panel are compiled first. */
`timescale 1ns/10ps
module tb_segment_lcd_control_regs
    import slcd_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, sub_clk_tick = 1'b0, osc_tick = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    slcd_level_t [SEG_COUNT-1:0] seg_level;
    slcd_level_t [COM_COUNT-1:0] com_level;
    slcd_drive_t drive_cfg;
    slcd_pinsel_t pin_sel;
    logic [SEG_COUNT-1:0] pix_on;
    logic [7:0] tick_cnt = '0;
    logic [2:0] seen;
    int num_errors = 0, checks_done = 0;
    // Rows: register, value written, value read back
    logic [15:0] ra [6] = '{IDX_DRIVE_VOLTAGE, IDX_DISPLAY_MODE, IDX_DISPLAY_CLOCK,
        IDX_PIN_SEL_PORT0, IDX_PIN_SEL_PORT3, IDX_PIN_SEL_GROUPED};
    // Reserved bits are written as zero; no prohibited code is written
    logic [7:0] rw [6] = '{8'h30, 8'hc4, 8'h45, 8'ha5, 8'h5a, 8'hfe};
    logic [7:0] rx [6] = '{8'h30, 8'hc4, 8'h45, 8'ha5, 8'h5a, 8'hfe};
    slcd_ctrl uut (.*);
    slcd_panel pan (.seg_level, .com_level, .pix_on);
    initial forever #12.5 clk = ~clk;
    // Fast stand-ins for the slow sources keep display ticks 64 cycles apart
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 8'h01;
        sub_clk_tick <= tick_cnt[1:0] == 2'h3;
        osc_tick <= tick_cnt[0];
    end
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic we, input logic [15:0] a, input logic [7:0] v);
        logic aw, w, ar, done;
        @(posedge clk);
        if (we) begin
            s_axi_awaddr <= {a, 2'b00};
            s_axi_wdata <= {24'h0, v};
            s_axi_wstrb <= 4'h1;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        end else begin
            s_axi_araddr <= {a, 2'b00};
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
        end
        forever begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            ar = s_axi_arvalid && s_axi_arready;
            done = we ? s_axi_bvalid : s_axi_rvalid;
            r = we ? s_axi_bresp : s_axi_rresp;
            d = s_axi_rdata;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (ar) s_axi_arvalid <= 1'b0;
            if (done) begin
                {s_axi_bready, s_axi_rready} <= 2'h0;
                break;
            end
        end
        // Registered outputs launched at the answer edge settle before any compare
        @(negedge clk);
    endtask : xfer
    task automatic conclude();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            xfer(0, ra[i], 8'h0);
            chk(d, 32'h0);
            xfer(1, ra[i], rw[i]);
            xfer(0, ra[i], 8'h0);
            chk(d, {24'h0, rx[i]});
        end
        chk(pin_sel, {8'ha5, 8'h5a, 7'h7f});
        chk(drive_cfg, 2'h3);
        xfer(1, IDX_DRIVE_VOLTAGE, 8'h10);
        chk(drive_cfg, 2'h2);
        xfer(0, 16'h0001, 8'h0);
        chk({d, r}, {32'h0, RESP_SLVERR});
        xfer(1, 16'h0001, 8'hff);
        chk(r, RESP_SLVERR);
        xfer(1, IDX_DISP_MEM_BASE, 8'h01);
        xfer(1, IDX_DISP_MEM_BASE + 16'h1, 8'h00);
        xfer(1, IDX_DISPLAY_CLOCK, 8'h00);
        xfer(1, IDX_DISPLAY_MODE, 8'hc4);
        repeat (150) @(negedge clk);
        chk(pix_on[1:0], 2'h1);
        chk(com_level[0], com_level[3]);
        xfer(1, IDX_DISPLAY_MODE, 8'hc1);
        repeat (150) @(negedge clk);
        chk(com_level[3], LV_GND);
        xfer(1, IDX_DISPLAY_MODE, 8'h44);
        repeat (150) @(negedge clk);
        chk(pix_on[1:0], 2'h0);
        xfer(1, IDX_DISPLAY_MODE, 8'h04);
        repeat (4) @(negedge clk);
        chk({seg_level, com_level}, '0);
        xfer(1, IDX_DRIVE_VOLTAGE, 8'h00);
        chk(drive_cfg, 2'h0);
        xfer(1, IDX_DISPLAY_MODE, 8'hc0);
        seen = '0;
        repeat (300) @(negedge clk) seen = seen | {pix_on[1], pix_on[0], com_level[3] != LV_GND};
        chk(seen, 3'h3);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        xfer(0, IDX_DISPLAY_MODE, 8'h0);
        chk(d, 32'h0);
        conclude();
    end
    initial begin
        repeat (10000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule : tb_segment_lcd_control_regs
